//--- hdl/ddr2_col_map.svh
`ifndef DDR2_COL_MAP_SVH
`define DDR2_COL_MAP_SVH

// Page and segment geometry
`define COL_W          10
`define ADDR_W         11
`define PAGE_COLS      1024
`define SEG4_COUNT     256
`define SEG8_COUNT     128
`define AP_BIT         10

// Mode register fields
`define BL_CODE_W      3
`define BL4_CODE       3'h2
`define BL8_CODE       3'h3
`define LAT_W          3

// Data path
`define DQ_W           16
`define DM_W           2
`define LANE_W         8

// Burst timing, in beat pairs (one pair per clock)
`define BL4_LAST_PAIR  2'h1
`define BL8_LAST_PAIR  2'h3
`define RL_MIN         4'h2
`define TCCD_CYC       2

// Command delay line and write capture ring
`define PIPE_DEPTH     16
`define PIPE_IDX_W     4
`define RING_DEPTH     8
`define RING_PW        4

`endif

//--- hdl/ddr2_col_pkg.sv
`default_nettype none
`include "ddr2_col_map.svh"

package ddr2_col_pkg;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_PRE  = 3'b010,
        RD_DATA = 3'b100
    } rd_state_t;

    typedef enum logic [2:0] {
        WR_IDLE   = 3'b001,
        WR_BURST  = 3'b010,
        WR_QUEUED = 3'b100
    } wr_state_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic              ap;
        logic [`COL_W-1:0] col;
    } col_cmd_t;

    typedef struct packed {
        logic [`DM_W-1:0] dm_fall;
        logic [`DM_W-1:0] dm_rise;
        logic [`DQ_W-1:0] dq_fall;
        logic [`DQ_W-1:0] dq_rise;
    } wr_pair_t;

endpackage

`default_nettype wire

//--- hdl/sync_2ff.sv
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_d;
            sync_ff <= meta_ff;
        end
    end

    assign o_q = sync_ff;

endmodule

`default_nettype wire

//--- hdl/burst_col_order.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddr2_col_map.svh"

module burst_col_order (
    input  wire logic [`COL_W-1:0] i_start,
    input  wire logic [2:0]        i_beat,
    input  wire logic              i_bl8,
    input  wire logic              i_interleave,
    output logic      [`COL_W-1:0] o_col
);

    logic [1:0] low;
    logic       mid;

    always_comb begin
        // Interleave: start xor beat; sequential: wrap inside the nibble
        low = i_interleave ? (i_start[1:0] ^ i_beat[1:0])
                           : (i_start[1:0] + i_beat[1:0]);
        // Second nibble only for eight-beat bursts
        mid = i_bl8 ? (i_start[2] ^ i_beat[2]) : i_start[2];
    end

    assign o_col = {i_start[`COL_W-1:3], mid, low};

endmodule

`default_nettype wire

//--- hdl/ddr2_column_burst_access.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddr2_col_map.svh"

module ddr2_column_burst_access
    import ddr2_col_pkg::*;
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_clk_en,
    input  wire logic                  i_wr_strobe_clk,
    input  wire logic                  i_cs_n,
    input  wire logic                  i_ras_n,
    input  wire logic                  i_cas_n,
    input  wire logic                  i_we_n,
    input  wire logic [`ADDR_W-1:0]    i_addr,
    input  wire logic [`BL_CODE_W-1:0] i_mr_burst_len,
    input  wire logic                  i_mr_burst_type,
    input  wire logic [`LAT_W-1:0]     i_mr_cas_lat,
    input  wire logic [`LAT_W-1:0]     i_emr_add_lat,
    input  wire logic [`DQ_W-1:0]      i_dq_rise,
    input  wire logic [`DQ_W-1:0]      i_dq_fall,
    input  wire logic [`DM_W-1:0]      i_dm_rise,
    input  wire logic [`DM_W-1:0]      i_dm_fall,
    output logic      [`DQ_W-1:0]      o_dq_rise,
    output logic      [`DQ_W-1:0]      o_dq_fall,
    output logic                       o_dq_oe_n,
    output logic                       o_dqs,
    output logic                       o_dqs_oe_n,
    output logic                       o_rd_busy,
    output logic                       o_wr_busy,
    output logic                       o_auto_pre,
    output logic                       o_cfg_err
);

    function automatic logic [`RING_PW-1:0] gray2bin(input logic [`RING_PW-1:0] g);
        logic [`RING_PW-1:0] b;
        b[`RING_PW-1] = g[`RING_PW-1];
        for (int i = `RING_PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Command decode; no terminate command is decoded
    logic                   cmd_sel;
    logic                   cmd_rd;
    logic                   cmd_wr;
    logic                   cmd_nop;
    logic                   bl8;
    logic [3:0]             rl;
    logic [`PIPE_IDX_W-1:0] tap_idx;
    col_cmd_t               new_cmd;
    col_cmd_t               tap;
    col_cmd_t               pipe_ff [`PIPE_DEPTH];

    assign cmd_sel = !i_cs_n;
    assign cmd_rd  = cmd_sel && i_ras_n && !i_cas_n && i_we_n;
    assign cmd_wr  = cmd_sel && i_ras_n && !i_cas_n && !i_we_n;
    assign cmd_nop = cmd_sel && i_ras_n && i_cas_n && i_we_n;
    assign bl8     = (i_mr_burst_len == `BL8_CODE);
    assign rl      = 4'(i_emr_add_lat) + 4'(i_mr_cas_lat);
    assign tap_idx = (rl < `RL_MIN) ? '0 : rl - `RL_MIN;

    always_comb begin
        new_cmd     = '0;
        new_cmd.rd  = cmd_rd;
        new_cmd.wr  = cmd_wr;
        new_cmd.ap  = (cmd_rd || cmd_wr) && i_addr[`AP_BIT];
        new_cmd.col = (cmd_rd || cmd_wr) ? i_addr[`COL_W-1:0] : '0;
    end

    // Posted commands wait in the delay line for AL + CL - 2 clocks
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < `PIPE_DEPTH; i++) begin
                pipe_ff[i] <= '0;
            end
        end else if (i_clk_en) begin
            pipe_ff[0] <= new_cmd;
            for (int i = 1; i < `PIPE_DEPTH; i++) begin
                pipe_ff[i] <= pipe_ff[i-1];
            end
        end
    end

    assign tap = pipe_ff[tap_idx];

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cfg_err <= 1'b0;
        end else if (i_clk_en) begin
            o_cfg_err <= !(bl8 || i_mr_burst_len == `BL4_CODE) || (rl < `RL_MIN);
        end
    end

    logic [1:0]        last_pair;
    logic [`DQ_W-1:0]  page_mem [`PAGE_COLS];
    assign last_pair = bl8 ? `BL8_LAST_PAIR : `BL4_LAST_PAIR;

    // Read engine
    rd_state_t         rd_state_ff;
    logic [`COL_W-1:0] rd_col_ff;
    logic              rd_ap_ff;
    logic [1:0]        rd_pair_ff;
    logic              rd_pend_ff;
    logic [`COL_W-1:0] pend_col_ff;
    logic              pend_ap_ff;
    logic              rd_go;
    logic              rd_cont;
    logic              rd_pre;
    logic              rd_end_ap;
    logic [`COL_W-1:0] rd_start;
    logic [1:0]        rd_pair_nxt;
    logic [`COL_W-1:0] rd_col_r;
    logic [`COL_W-1:0] rd_col_f;
    logic [`DQ_W-1:0]  dq_rise_ff;
    logic [`DQ_W-1:0]  dq_fall_ff;
    logic              dq_oe_n_ff;
    logic              dqs_ff;
    logic              dqs_oe_n_ff;

    // A pending read wins over the rest of an older burst (BL8 interrupt)
    assign rd_go       = rd_pend_ff;
    assign rd_cont     = !rd_go && rd_state_ff == RD_DATA && rd_pair_ff != last_pair;
    assign rd_pre      = !rd_go && !rd_cont && tap.rd;
    assign rd_end_ap   = rd_state_ff == RD_DATA && !rd_go && !rd_cont && rd_ap_ff;
    assign rd_start    = rd_go ? pend_col_ff : rd_col_ff;
    assign rd_pair_nxt = rd_go ? 2'h0 : rd_pair_ff + 2'h1;

    burst_col_order u_rd_rise (
        .i_start      (rd_start),
        .i_beat       ({rd_pair_nxt, 1'b0}),
        .i_bl8        (bl8),
        .i_interleave (i_mr_burst_type),
        .o_col        (rd_col_r)
    );

    burst_col_order u_rd_fall (
        .i_start      (rd_start),
        .i_beat       ({rd_pair_nxt, 1'b1}),
        .i_bl8        (bl8),
        .i_interleave (i_mr_burst_type),
        .o_col        (rd_col_f)
    );

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_pend_ff  <= 1'b0;
            pend_col_ff <= '0;
            pend_ap_ff  <= 1'b0;
        end else if (i_clk_en) begin
            rd_pend_ff  <= tap.rd;
            pend_col_ff <= tap.col;
            pend_ap_ff  <= tap.ap;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_state_ff <= RD_IDLE;
            rd_col_ff   <= '0;
            rd_ap_ff    <= 1'b0;
            rd_pair_ff  <= 2'h0;
        end else if (i_clk_en) begin
            if (rd_go || rd_cont) begin
                rd_state_ff <= RD_DATA;
                rd_pair_ff  <= rd_pair_nxt;
            end else if (rd_pre) begin
                rd_state_ff <= RD_PRE;
            end else begin
                rd_state_ff <= RD_IDLE;
            end
            if (rd_go) begin
                rd_col_ff <= pend_col_ff;
                rd_ap_ff  <= pend_ap_ff;
            end
        end
    end

    // Two beats per clock: strobe held high for every data clock, low in the preamble
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dq_rise_ff  <= '0;
            dq_fall_ff  <= '0;
            dq_oe_n_ff  <= 1'b1;
            dqs_ff      <= 1'b0;
            dqs_oe_n_ff <= 1'b1;
        end else if (i_clk_en) begin
            if (rd_go || rd_cont) begin
                dq_rise_ff <= page_mem[rd_col_r];
                dq_fall_ff <= page_mem[rd_col_f];
            end
            dq_oe_n_ff  <= !(rd_go || rd_cont);
            dqs_ff      <= rd_go || rd_cont;
            dqs_oe_n_ff <= !(rd_go || rd_cont || rd_pre);
        end
    end

    assign o_dq_rise  = dq_rise_ff;
    assign o_dq_fall  = dq_fall_ff;
    assign o_dq_oe_n  = dq_oe_n_ff;
    assign o_dqs      = dqs_ff;
    assign o_dqs_oe_n = dqs_oe_n_ff;
    assign o_rd_busy  = rd_state_ff != RD_IDLE;

    // Link side: one beat pair per rising strobe edge into the capture ring
    wr_pair_t             ring_mem [`RING_DEPTH];
    logic [`RING_PW-1:0]  wptr_bin_l_ff;
    logic [`RING_PW-1:0]  wptr_gray_l_ff;
    logic [`RING_PW-1:0]  wptr_gray_s;
    logic [`RING_PW-1:0]  wptr_bin_s;
    logic [`RING_PW-1:0]  nxt_wptr_bin_l;

    assign nxt_wptr_bin_l = wptr_bin_l_ff + 4'h1;

    always_ff @(posedge i_wr_strobe_clk) begin
        ring_mem[wptr_bin_l_ff[2:0]] <= {i_dm_fall, i_dm_rise, i_dq_fall, i_dq_rise};
    end

    always_ff @(posedge i_wr_strobe_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wptr_bin_l_ff  <= '0;
            wptr_gray_l_ff <= '0;
        end else begin
            wptr_bin_l_ff  <= nxt_wptr_bin_l;
            wptr_gray_l_ff <= nxt_wptr_bin_l ^ (nxt_wptr_bin_l >> 1);
        end
    end

    sync_2ff #(.W(`RING_PW)) u_wptr_sync (
        .i_clk     (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_d       (wptr_gray_l_ff),
        .o_q       (wptr_gray_s)
    );

    assign wptr_bin_s = gray2bin(wptr_gray_s);

    // Write engine: commit captured pairs into the page
    wr_state_t           wr_state_ff;
    logic [`COL_W-1:0]   w_col_ff;
    logic                w_ap_ff;
    logic [1:0]          w_pair_ff;
    logic [1:0]          w_last_ff;
    logic [1:0]          w_age_ff;
    logic [`COL_W-1:0]   wq_col_ff;
    logic                wq_ap_ff;
    logic [`RING_PW-1:0] ring_rd_ff;
    logic                w_commit;
    logic                w_done;
    logic [`COL_W-1:0]   w_col_r;
    logic [`COL_W-1:0]   w_col_f;
    wr_pair_t            w_ent;

    assign w_commit = wr_state_ff != WR_IDLE && ring_rd_ff != wptr_bin_s;
    assign w_done   = w_commit && w_pair_ff == w_last_ff;
    assign w_ent    = ring_mem[ring_rd_ff[2:0]];

    burst_col_order u_wr_rise (
        .i_start      (w_col_ff),
        .i_beat       ({w_pair_ff, 1'b0}),
        .i_bl8        (bl8),
        .i_interleave (i_mr_burst_type),
        .o_col        (w_col_r)
    );

    burst_col_order u_wr_fall (
        .i_start      (w_col_ff),
        .i_beat       ({w_pair_ff, 1'b1}),
        .i_bl8        (bl8),
        .i_interleave (i_mr_burst_type),
        .o_col        (w_col_f)
    );

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_state_ff <= WR_IDLE;
            w_col_ff    <= '0;
            w_ap_ff     <= 1'b0;
            w_pair_ff   <= 2'h0;
            w_last_ff   <= `BL4_LAST_PAIR;
            w_age_ff    <= 2'h0;
            wq_col_ff   <= '0;
            wq_ap_ff    <= 1'b0;
            ring_rd_ff  <= '0;
        end else if (i_clk_en) begin
            if (w_age_ff != 2'h3) begin
                w_age_ff <= w_age_ff + 2'h1;
            end
            if (w_commit) begin
                ring_rd_ff <= ring_rd_ff + 4'h1;
                w_pair_ff  <= w_pair_ff + 2'h1;
            end
            unique case (wr_state_ff)
                WR_IDLE: begin
                    if (tap.wr) begin
                        wr_state_ff <= WR_BURST;
                        w_col_ff    <= tap.col;
                        w_ap_ff     <= tap.ap;
                        w_pair_ff   <= 2'h0;
                        w_last_ff   <= last_pair;
                        w_age_ff    <= 2'h0;
                        ring_rd_ff  <= wptr_bin_s;
                    end
                end
                WR_BURST: begin
                    if (tap.wr && w_done) begin
                        w_col_ff  <= tap.col;
                        w_ap_ff   <= tap.ap;
                        w_pair_ff <= 2'h0;
                        w_last_ff <= last_pair;
                        w_age_ff  <= 2'h0;
                    end else if (tap.wr) begin
                        wr_state_ff <= WR_QUEUED;
                        wq_col_ff   <= tap.col;
                        wq_ap_ff    <= tap.ap;
                        // Burst interrupted before w_age_ff reaches w_last_ff keeps its first four beats only
                        if (w_age_ff < w_last_ff) begin
                            w_last_ff <= `BL4_LAST_PAIR;
                        end
                    end else if (w_done) begin
                        wr_state_ff <= WR_IDLE;
                    end
                end
                WR_QUEUED: begin
                    if (w_done) begin
                        wr_state_ff <= WR_BURST;
                        w_col_ff    <= wq_col_ff;
                        w_ap_ff     <= wq_ap_ff;
                        w_pair_ff   <= 2'h0;
                        w_last_ff   <= last_pair;
                        w_age_ff    <= 2'h3;
                    end
                end
            endcase
        end
    end

    // Mask high keeps the byte; masks only matter on committed write beats
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && w_commit) begin
            for (int b = 0; b < `DM_W; b++) begin
                if (!w_ent.dm_rise[b]) begin
                    page_mem[w_col_r][b*`LANE_W +: `LANE_W] <= w_ent.dq_rise[b*`LANE_W +: `LANE_W];
                end
                if (!w_ent.dm_fall[b]) begin
                    page_mem[w_col_f][b*`LANE_W +: `LANE_W] <= w_ent.dq_fall[b*`LANE_W +: `LANE_W];
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_auto_pre <= 1'b0;
        end else if (i_clk_en) begin
            o_auto_pre <= rd_end_ap || (w_done && w_ap_ff);
        end
    end

    assign o_wr_busy = wr_state_ff != WR_IDLE;

    // Checking helpers: latency from the first command of a quiet period
    logic       chk_rd_on_ff;
    logic [3:0] chk_rd_cnt_ff;
    logic       chk_wr_on_ff;
    logic [3:0] chk_wr_cnt_ff;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            chk_rd_on_ff  <= 1'b0;
            chk_rd_cnt_ff <= 4'h0;
            chk_wr_on_ff  <= 1'b0;
            chk_wr_cnt_ff <= 4'h0;
        end else if (i_clk_en) begin
            chk_rd_cnt_ff <= chk_rd_on_ff ? chk_rd_cnt_ff + 4'h1 : 4'h0;
            chk_wr_cnt_ff <= chk_wr_on_ff ? chk_wr_cnt_ff + 4'h1 : 4'h0;
            if (!chk_rd_on_ff && cmd_rd && !o_rd_busy) begin
                chk_rd_on_ff <= 1'b1;
            end else if (chk_rd_cnt_ff == rl) begin
                chk_rd_on_ff <= 1'b0;
            end
            if (!chk_wr_on_ff && cmd_wr && !o_wr_busy) begin
                chk_wr_on_ff <= 1'b1;
            end else if (chk_wr_cnt_ff == rl - 4'h1) begin
                chk_wr_on_ff <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n || !i_clk_en);

    sequence s_preamble;
        rd_state_ff == RD_PRE && !o_dqs_oe_n && !o_dqs && o_dq_oe_n;
    endsequence

    sequence s_first_pair;
        rd_state_ff == RD_DATA && rd_pair_ff == 2'h0 && !o_dq_oe_n && o_dqs;
    endsequence

    a_nop_no_effect: assert property (cmd_nop |=> pipe_ff[0] == '0)
        else $error("nop entered the command delay line");
    a_deselect_ignored: assert property (i_cs_n |=> !pipe_ff[0].rd && !pipe_ff[0].wr)
        else $error("deselected command was decoded");
    a_read_latency: assert property (chk_rd_on_ff && chk_rd_cnt_ff == rl |-> s_first_pair)
        else $error("first read data not at read latency");
    a_preamble_seq: assert property (s_preamble |=> s_first_pair)
        else $error("strobe preamble not followed by data");
    a_preamble_early: assert property (
        chk_rd_on_ff && chk_rd_cnt_ff == rl - 4'h1 |-> !o_dqs_oe_n)
        else $error("strobe not driven one clock before read data");
    a_write_latency: assert property (
        chk_wr_on_ff && chk_wr_cnt_ff == rl - 4'h1 |-> o_wr_busy)
        else $error("write burst not opened at write latency");
    a_segment_bound: assert property (
        rd_go || rd_cont |-> rd_col_r[`COL_W-1:3] == rd_start[`COL_W-1:3]
            && (bl8 || rd_col_f[2] == rd_start[2]))
        else $error("read burst left its segment");
    a_interleave_map: assert property (
        i_mr_burst_type && w_commit |->
            (w_col_f[2:0] ^ w_col_ff[2:0]) == {bl8 && w_pair_ff[1], w_pair_ff[0], 1'b1})
        else $error("interleaved write order wrong");
    a_seq_wrap: assert property (
        !i_mr_burst_type && (rd_go || rd_cont) |->
            rd_col_f[1:0] == rd_start[1:0] + {rd_pair_nxt[0], 1'b1})
        else $error("sequential read order wrong");
    a_beats_bounded: assert property (
        w_commit && w_pair_ff == w_last_ff |=> wr_state_ff != WR_BURST || w_pair_ff == 2'h0)
        else $error("write kept capturing past burst length");
    a_bl_config: assert property (!(bl8 || i_mr_burst_len == `BL4_CODE) |=> o_cfg_err)
        else $error("unsupported burst length not flagged");

endmodule

`default_nettype wire

//--- dv/ddr2_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ddr2_ctrl_model (
    output logic        o_strobe,
    output logic [15:0] o_dq_rise,
    output logic [15:0] o_dq_fall,
    output logic [1:0]  o_dm_rise,
    output logic [1:0]  o_dm_fall
);
    initial o_strobe = 1'b0;
    initial {o_dq_rise, o_dq_fall, o_dm_rise, o_dm_fall} = '0;
    task automatic pair(input logic [15:0] r, f, input logic [1:0] m);
        o_dq_rise = r;
        o_dq_fall = f;
        o_dm_rise = m;
        o_dm_fall = m;
        #3.75 o_strobe = 1'b1;
        #7.5 o_strobe = 1'b0;
        #3.75;
    endtask
    task automatic idle();
        o_dq_rise = ~o_dq_rise; // Released data lines never keep the last value; the mask lines do
        o_dq_fall = ~o_dq_fall;
    endtask
endmodule
`default_nettype wire

//--- dv/test_ddr2_column_burst_access.sv
`timescale 1ns/10ps
`default_nettype none
`include "ddr2_col_map.svh"
module test_ddr2_column_burst_access;
    typedef struct packed {int at; logic [31:0] d;} exp_t;
    localparam int RL = 5;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  cmd_n = 4'hf;
    logic [10:0] addr = '0;
    logic [2:0]  bl = `BL4_CODE;
    logic        il = 1'b0;
    logic [15:0] mem [1024];
    logic [15:0] dqr, dqf, odr, odf;
    logic [1:0]  dmr, dmf;
    logic        stb, dq_oe_n, dqs, dqs_oe_n, rd_busy, wr_busy, ap, cfg_err;
    logic        pre_oe_n = 1'b1;
    logic        ce = 1'b1;
    int          fail_count = 0, n_tests = 0, nc = 0, ap_cnt = 0, seed = 99;
    exp_t        q[$];
    exp_t        ex;
    always #20 clk = ~clk;
    ddr2_ctrl_model pm_u (.o_strobe(stb), .o_dq_rise(dqr), .o_dq_fall(dqf),
        .o_dm_rise(dmr), .o_dm_fall(dmf));
    ddr2_column_burst_access dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce),
        .i_wr_strobe_clk(stb), .i_cs_n(cmd_n[3]), .i_ras_n(cmd_n[2]), .i_cas_n(cmd_n[1]),
        .i_we_n(cmd_n[0]), .i_addr(addr), .i_mr_burst_len(bl), .i_mr_burst_type(il),
        .i_mr_cas_lat(3'h3), .i_emr_add_lat(3'h2), .i_dq_rise(dqr), .i_dq_fall(dqf),
        .i_dm_rise(dmr), .i_dm_fall(dmf), .o_dq_rise(odr), .o_dq_fall(odf),
        .o_dq_oe_n(dq_oe_n), .o_dqs(dqs), .o_dqs_oe_n(dqs_oe_n), .o_rd_busy(rd_busy),
        .o_wr_busy(wr_busy), .o_auto_pre(ap), .o_cfg_err(cfg_err));
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e || $isunknown(g)) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [9:0] ord(logic [9:0] s, int k);
        logic [2:0] b;
        b = k[2:0];
        if (il) return s ^ 10'(b);
        if (bl == `BL8_CODE) return {s[9:3], s[2] ^ b[2], s[1:0] + b[1:0]};
        return {s[9:2], s[1:0] + b[1:0]};
    endfunction
    function automatic void upd(logic [9:0] c, logic [15:0] v, logic [1:0] m);
        if (!m[0]) mem[c][7:0] = v[7:0];
        if (!m[1]) mem[c][15:8] = v[15:8];
    endfunction
    task automatic cmd(input logic w, input logic [10:0] a);
        @(posedge clk);
        cmd_n <= {3'b010, w};
        addr <= a;
        @(posedge clk);
        cmd_n <= 4'hf;
    endtask
    task automatic rd(input logic [10:0] a, input logic intr);
        int n;
        cmd(1'b1, a);
        n = (bl == `BL8_CODE) ? 4 : 2;
        if (intr) repeat (2) void'(q.pop_back());
        for (int j = 0; j < n; j++)
            q.push_back({32'(nc + 1 + RL + j), mem[ord(a[9:0], 2*j)], mem[ord(a[9:0], 2*j+1)]});
    endtask
    task automatic wr(input logic [9:0] c, input logic [1:0] m);
        logic [15:0] r, f;
        int n;
        cmd(1'b0, {1'b0, c});
        n = (bl == `BL8_CODE) ? 4 : 2;
        repeat (RL - 1) @(posedge clk);
        #5;
        for (int j = 0; j <= n; j++) begin
            r = 16'($random(seed));
            f = 16'($random(seed));
            if (j < n) upd(ord(c, 2*j), r, m);
            if (j < n) upd(ord(c, 2*j+1), f, m);
            pm_u.pair(r, f, m);
        end
        pm_u.idle();
        for (int t = 0; t < 20 && wr_busy !== 1'b0; t++) @(posedge clk);
    endtask
    task automatic fin(input string nm);
        for (int t = 0; t < 40 && (q.size() != 0 || rd_busy !== 1'b0); t++) @(posedge clk);
        chk("pending reads", 0, 32'(q.size()));
        chk("write busy", 0, 32'(wr_busy));
        $display("test %s done", nm);
    endtask
    always @(negedge clk) begin
        nc++;
        if (ap === 1'b1) ap_cnt++;
        if (dq_oe_n === 1'b0) begin
            chk("strobe enable", 0, 32'(pre_oe_n));
            chk("strobe", 1, 32'(dqs));
            chk("read busy", 1, 32'(rd_busy));
            if (q.size() == 0) chk("unexpected data", 0, 1);
            else begin
                ex = q.pop_front();
                chk("latency", 32'(ex.at), 32'(nc));
                chk("data", ex.d, {odr, odf});
            end
        end else if (dqs_oe_n === 1'b0) chk("preamble", 0, 32'(dqs));
        pre_oe_n = dqs_oe_n;
    end
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wr(10'h010, 2'b00);
        rd(11'h011, 1'b0);
        rd(11'h012, 1'b0);
        fin("seq4");
        il <= 1'b1;
        wr(10'h011, 2'b10);
        rd(11'h413, 1'b0);
        fin("mask");
        chk("auto precharge", 1, 32'(ap_cnt));
        repeat (16) begin
            @(posedge clk);
            cmd_n <= ($random(seed) & 1) ? {1'b1, 3'($random(seed))}
                                         : {3'b011, 1'($random(seed))};
            addr <= 11'($random(seed));
        end
        @(posedge clk);
        cmd_n <= 4'hf;
        ce <= 1'b0;
        cmd(1'b1, 11'h010);
        ce <= 1'b1;
        il <= 1'b0;
        rd(11'h010, 1'b0);
        fin("idle");
        bl <= `BL8_CODE;
        wr(10'h024, 2'b00);
        wr(10'h020, 2'b01);
        rd(11'h025, 1'b0);
        rd(11'h022, 1'b1);
        fin("seq8");
        il <= 1'b1;
        rd(11'h025, 1'b0);
        fin("il8");
        bl <= 3'h7;
        repeat (3) @(posedge clk);
        chk("config error", 1, 32'(cfg_err));
        $display("test config done");
        test_done();
    end
endmodule
`default_nettype wire
